// ### design/mrs_defs.svh
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH
// Data widths and fixed values
`define MRS_ZERO_BYTE 8'h00
`define MRS_ONES_BYTE 8'hFF
`define MRS_ONE_BYTE 8'h01
`define MRS_MSB 7
`define MRS_MSB_NEXT 6
`define MRS_LSB 0
`define MRS_LSB_NEXT 1
`define MRS_CARRY_BIT 8
`define MRS_NIB_HI 7
`define MRS_NIB_HI_LO 4
`define MRS_NIB_LO 3
// Reset values
`define MRS_RST_WORK 8'h00
`define MRS_RST_CARRY 1'b0
`endif

// ### design/mrs_pkg.sv
package mrs_pkg;
   // Operation select codes
   typedef enum logic [4:0] {
      MRS_OP_NONE = 5'h00,
      MRS_OP_ROLC_W = 5'h01,
      MRS_OP_ROR_M = 5'h02,
      MRS_OP_ROR_W = 5'h03,
      MRS_OP_RORC_M = 5'h04,
      MRS_OP_RORC_W = 5'h05,
      MRS_OP_SUBC_W = 5'h06,
      MRS_OP_SUBC_M = 5'h07,
      MRS_OP_SUB = 5'h08,
      MRS_OP_SUB_M = 5'h09,
      MRS_OP_SUBI = 5'h0A,
      MRS_OP_DSZ = 5'h0B,
      MRS_OP_DSZW = 5'h0C,
      MRS_OP_SETB = 5'h0D,
      MRS_OP_SETBIT = 5'h0E,
      MRS_OP_ISZ = 5'h0F,
      MRS_OP_ISZW = 5'h10,
      MRS_OP_SBS = 5'h11,
      MRS_OP_NSW = 5'h12,
      MRS_OP_NSWW = 5'h13,
      MRS_OP_SZB = 5'h14
   } mrs_op_t;
   // Execution phase
   typedef enum logic [0:0] {
      MRS_ST_EXEC = 1'b0,
      MRS_ST_DUMMY = 1'b1
   } mrs_state_t;
   // Whole module state
   typedef struct packed {
      mrs_state_t state;
      logic [7:0] working_register;
      logic carry;
      logic half_carry_flag;
      logic zero;
      logic signed_range_error_flag;
      logic [7:0] mem_wdata;
      logic mem_we;
      logic busy;
      logic fetch_discard;
      logic done;
   } mrs_regs_t;
endpackage

// ### design/mrs_datapath.sv
`timescale 1ns/1ps
`include "mrs_defs.svh"
// Functional notes
// - Left rotate through carry into working register
// - Right rotate memory, bit0 to bit7
// - Right rotate into working register, no flags
// - Right rotate memory through carry
// - Right rotate through carry into working
// - Working plus inverted memory plus carry
// - Working plus inverted memory plus one
// - Working plus inverted immediate plus one
// - Decrement memory, skip when result zero
// - Decrement into working, same skip timing
// - Set whole memory byte to ones
// - Force selected memory bit high
// - Increment memory, skip when result zero
// - Increment into working, skip on zero
// - Skip when selected bit is one
// - Swap memory nibbles, write back
// - Swapped nibbles into working register
// - Skip when memory byte is zero
// - Skip taken costs two cycles, else one
module mrs_datapath #(
   parameter int DATA_W = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic op_valid,
   input wire mrs_pkg::mrs_op_t op_code,
   input wire logic [DATA_W-1:0] mem_rdata,
   input wire logic [DATA_W-1:0] imm_data,
   input wire logic [2:0] bit_sel,
   output logic [DATA_W-1:0] working_register,
   output logic carry,
   output logic half_carry_flag,
   output logic zero,
   output logic signed_range_error_flag,
   output logic [DATA_W-1:0] mem_wdata,
   output logic mem_we,
   output logic busy,
   output logic fetch_discard,
   output logic done
);
   import mrs_pkg::*;
   // The block executes one op per cycle, two for a taken skip, and owns the working register
   // and the four arithmetic flags; memory itself lives outside and is
   // seen only through the read byte and the registered write strobe.

   // Adder result bundle: sum, carry out, half carry, overflow
   // Kept local since nothing outside the adder needs the bundle.
   typedef struct packed {
      logic [7:0] sum;
      logic c;
      logic h;
      logic v;
   } mrs_sum_t;

   mrs_regs_t r; // Registered state
   mrs_regs_t next_r; // Next state
   // All state lives in one struct: the decode below fills a copy and a
   // single flip-flop process stores it, so every output is registered.
   // Strobes in the struct are cleared by default on every cycle, which
   // keeps a stale write enable from being replayed by a later op.

   // Shared add-with-carry for every subtract form.
   // Subtraction is a plus the inverted operand plus a carry-in, so the
   // carry out reads as "no borrow". Half carry is the carry out of the
   // low nibble; overflow is the signed overflow of that same addition.
   // One adder for all five forms keeps their flag rules identical.
   function automatic mrs_sum_t mrs_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
      mrs_sum_t s;
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[`MRS_NIB_LO:`MRS_LSB]} + {1'b0, b[`MRS_NIB_LO:`MRS_LSB]} + {4'h0, cin};
      s.sum = full[`MRS_MSB:`MRS_LSB];
      s.c = full[`MRS_CARRY_BIT];
      s.h = low[`MRS_NIB_HI_LO];
      // Overflow when operands agree in sign and the result does not
      s.v = (a[`MRS_MSB] == b[`MRS_MSB]) && (full[`MRS_MSB] != a[`MRS_MSB]);
      return s;
   endfunction

   // Left rotate through carry: old carry enters bit 0.
   // The bit pushed out of bit 7 is left for the caller to
   // route into the carry flag.
   function automatic logic [7:0] mrs_rol_c(input logic [7:0] d, input logic cin);
      return {d[`MRS_MSB_NEXT:`MRS_LSB], cin};
   endfunction

   // Plain right rotate: bit 0 wraps round into bit 7.
   // Shared by the memory and working destinations so that the
   // two forms can never drift apart.
   function automatic logic [7:0] mrs_ror(input logic [7:0] d);
      return {d[`MRS_LSB], d[`MRS_MSB:`MRS_LSB_NEXT]};
   endfunction

   // Right rotate through carry: old carry enters bit 7.
   // Bit 0 falls out and becomes the new carry in the caller.
   // Nine bits rotate as one ring, carry included.
   function automatic logic [7:0] mrs_ror_c(input logic [7:0] d, input logic cin);
      return {cin, d[`MRS_MSB:`MRS_LSB_NEXT]};
   endfunction

   // Nibble exchange: low half moves up, high half moves down.
   // Applying it twice gives the original byte back.
   // Used for both the write-back and the working forms.
   function automatic logic [7:0] mrs_swap(input logic [7:0] d);
      return {d[`MRS_NIB_LO:`MRS_LSB], d[`MRS_NIB_HI:`MRS_NIB_HI_LO]};
   endfunction

   // Operation decode and skip sequencing.
   // One op is taken per edge while in the execute phase. Results land in
   // the struct copy and appear on the ports one cycle after the take.
   // A taken skip moves to a one-cycle dummy phase: the prefetched word is
   // flagged for discard at once and completion is reported a cycle later.
   // Ops offered during the dummy phase are ignored; the fetch unit is
   // expected to hold them until busy falls.
   // Memory is never read back here: mem_rdata must carry the addressed
   // byte in the same cycle as op_valid.
   always_comb
   begin
      mrs_sum_t s;
      logic [7:0] dec_v;
      logic [7:0] inc_v;
      logic skip;
      s = '0;
      // Both step results are formed every cycle; only the decrement and
      // increment forms look at them. Eight-bit arithmetic wraps on
      // purpose, so 00 minus one gives FF and FF plus one gives 00.
      dec_v = mem_rdata - `MRS_ONE_BYTE;
      inc_v = mem_rdata + `MRS_ONE_BYTE;
      skip = 1'b0;
      next_r = r;
      // Strobes last one cycle only
      // Everything else holds unless a branch below changes it, which is
      // how untouched flags keep their value across an op.
      next_r.mem_we = 1'b0;
      next_r.fetch_discard = 1'b0;
      next_r.done = 1'b0;
      // Two phases only: execute, or the dummy cycle that follows a
      // taken skip. The dummy phase always returns to execute, so the
      // block can never stall for longer than one cycle.
      case (r.state)
         MRS_ST_DUMMY:
         begin
            // Dummy cycle replaces the discarded prefetch
            // No result or flag changes here; the op that caused the skip
            // has already stored its result one cycle earlier.
            // Done marks the end of the two-cycle instruction.
            next_r.state = MRS_ST_EXEC;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
         end
         MRS_ST_EXEC:
         begin
            // New operations are ignored during the dummy cycle only
            if (op_valid)
            begin
               case (op_code)
                  MRS_OP_ROLC_W:
                  begin
                     // Result goes to working only; memory is left alone
                     // and bit 7 drops into carry
                     next_r.working_register = mrs_rol_c(mem_rdata, r.carry);
                     next_r.carry = mem_rdata[`MRS_MSB];
                  end
                  MRS_OP_ROR_M:
                  begin
                     // Write back only; every flag keeps its value
                     next_r.mem_wdata = mrs_ror(mem_rdata);
                     next_r.mem_we = 1'b1;
                  end
                  MRS_OP_ROR_W:
                  begin
                     // Same rotation, working destination, no write strobe
                     next_r.working_register = mrs_ror(mem_rdata);
                  end
                  MRS_OP_RORC_M:
                  begin
                     // Old carry goes in at the top, bit 0 comes out as carry
                     next_r.mem_wdata = mrs_ror_c(mem_rdata, r.carry);
                     next_r.mem_we = 1'b1;
                     next_r.carry = mem_rdata[`MRS_LSB];
                  end
                  MRS_OP_RORC_W:
                  begin
                     // As above but into working; memory stays intact
                     next_r.working_register = mrs_ror_c(mem_rdata, r.carry);
                     next_r.carry = mem_rdata[`MRS_LSB];
                  end
                  MRS_OP_SUBC_W, MRS_OP_SUBC_M, MRS_OP_SUB, MRS_OP_SUB_M, MRS_OP_SUBI:
                  begin
                     // All five forms share one adder: subtraction is done as an
                     // addition of the inverted operand, so carry set means no borrow.
                     // Only the carry-in, the second operand and the destination differ between them.
                     // Borrow forms feed the old carry, plain forms feed one
                     if (op_code == MRS_OP_SUBC_W || op_code == MRS_OP_SUBC_M)
                     begin
                        s = mrs_add(r.working_register, ~mem_rdata, r.carry);
                     end
                     else if (op_code == MRS_OP_SUBI)
                     begin
                        s = mrs_add(r.working_register, ~imm_data, 1'b1);
                     end
                     else
                     begin
                        s = mrs_add(r.working_register, ~mem_rdata, 1'b1);
                     end
                     // Memory destination variants write back instead
                     // Flags below are updated whatever the destination
                     // so that a write-back form still leaves a usable status.
                     if (op_code == MRS_OP_SUBC_M || op_code == MRS_OP_SUB_M)
                     begin
                        next_r.mem_wdata = s.sum;
                        next_r.mem_we = 1'b1;
                     end
                     else
                     begin
                        next_r.working_register = s.sum;
                     end
                     next_r.carry = s.c;
                     next_r.half_carry_flag = s.h;
                     next_r.signed_range_error_flag = s.v;
                     next_r.zero = (s.sum == `MRS_ZERO_BYTE);
                  end
                  MRS_OP_DSZ:
                  begin
                     next_r.mem_wdata = dec_v;
                     next_r.mem_we = 1'b1;
                     skip = (dec_v == `MRS_ZERO_BYTE);
                  end
                  MRS_OP_DSZW:
                  begin
                     next_r.working_register = dec_v;
                     skip = (dec_v == `MRS_ZERO_BYTE);
                  end
                  MRS_OP_SETB:
                  begin
                     next_r.mem_wdata = `MRS_ONES_BYTE;
                     next_r.mem_we = 1'b1;
                  end
                  MRS_OP_SETBIT:
                  begin
                     next_r.mem_wdata = mem_rdata | (`MRS_ONE_BYTE << bit_sel);
                     next_r.mem_we = 1'b1;
                  end
                  MRS_OP_ISZ:
                  begin
                     next_r.mem_wdata = inc_v;
                     next_r.mem_we = 1'b1;
                     skip = (inc_v == `MRS_ZERO_BYTE);
                  end
                  MRS_OP_ISZW:
                  begin
                     next_r.working_register = inc_v;
                     skip = (inc_v == `MRS_ZERO_BYTE);
                  end
                  MRS_OP_SBS:
                  begin
                     skip = mem_rdata[bit_sel];
                  end
                  MRS_OP_NSW:
                  begin
                     // Halves exchanged and written back; flags untouched
                     next_r.mem_wdata = mrs_swap(mem_rdata);
                     next_r.mem_we = 1'b1;
                  end
                  MRS_OP_NSWW:
                  begin
                     // Exchanged byte lands in working; no write strobe
                     next_r.working_register = mrs_swap(mem_rdata);
                  end
                  MRS_OP_SZB:
                  begin
                     skip = (mem_rdata == `MRS_ZERO_BYTE);
                  end
                  default:
                  begin
                     // No operation: nothing changes
                  end
               endcase
               // The skip decision uses only this cycle's inputs, so the
               // discard strobe rises in the same cycle as the results.
               // A skip never blocks the write-back of the op that caused it;
               // the decrement and increment forms still store their result.
               // Taken skip: drop prefetch and spend one dummy cycle
               if (skip)
               begin
                  next_r.state = MRS_ST_DUMMY;
                  next_r.busy = 1'b1;
                  next_r.fetch_discard = 1'b1;
               end
               else
               begin
                  next_r.done = 1'b1; // Single cycle completion
               end
            end
         end
         default:
         begin
            next_r.state = MRS_ST_EXEC;
         end
      endcase
   end

   // State register.
   // Asynchronous reset clears the whole struct to constants first; the
   // named fields are then given their reset values from the defines so
   // that a change of those values touches one place only.
   // Out of reset the flops simply copy the next-state struct.
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r <= '0;
         r.state <= MRS_ST_EXEC;
         r.working_register <= `MRS_RST_WORK;
         r.carry <= `MRS_RST_CARRY;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Outputs come straight from the state register.
   // Nothing combinational sits between the flops and the ports, which
   // keeps the timing of the result paths independent of the decode.
   // The price is one cycle of latency on every result and flag; the
   // surrounding pipeline is built around that delay.
   assign working_register = r.working_register;
   assign carry = r.carry;
   assign half_carry_flag = r.half_carry_flag;
   assign zero = r.zero;
   assign signed_range_error_flag = r.signed_range_error_flag;
   assign mem_wdata = r.mem_wdata;
   assign mem_we = r.mem_we;
   assign busy = r.busy;
   assign fetch_discard = r.fetch_discard;
   assign done = r.done;
endmodule

// ### verification/mrs_datapath_checker.sv
`timescale 1ns/1ps
module mrs_datapath_checker
   import mrs_pkg::*;
#(
   parameter int DATA_W = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic op_valid,
   input wire mrs_pkg::mrs_op_t op_code,
   input wire logic [DATA_W-1:0] mem_rdata,
   input wire logic [DATA_W-1:0] imm_data,
   input wire logic [2:0] bit_sel,
   input wire logic [DATA_W-1:0] working_register,
   input wire logic carry,
   input wire logic half_carry_flag,
   input wire logic zero,
   input wire logic signed_range_error_flag,
   input wire logic [DATA_W-1:0] mem_wdata,
   input wire logic mem_we,
   input wire logic busy,
   input wire logic fetch_discard,
   input wire logic done
);
   logic taken; // Op accepted at this edge
   logic skip_c; // Skip condition worked out from the inputs
   logic [3:0] flg; // All flags together
   logic [7:0] m_q, w_q, x_q; // Inputs one edge back, avoids $past of slices
   logic c_q;
   assign taken = op_valid && !busy;
   assign flg = {carry, half_carry_flag, zero, signed_range_error_flag};
   // Skip condition per operation
   always_comb
   begin
      case (op_code)
         MRS_OP_DSZ, MRS_OP_DSZW: skip_c = (mem_rdata == 8'h01);
         MRS_OP_ISZ, MRS_OP_ISZW: skip_c = (mem_rdata == 8'hFF);
         MRS_OP_SBS: skip_c = mem_rdata[bit_sel];
         MRS_OP_SZB: skip_c = (mem_rdata == 8'h00);
         default: skip_c = 1'b0;
      endcase
   end
   // History registers, no reset needed since only read after a take
   always_ff @(posedge mclk)
   begin
      m_q <= mem_rdata;
      w_q <= working_register;
      x_q <= imm_data;
      c_q <= carry;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence dummy_s;
      fetch_discard && busy && !done ##1 done && !busy && !fetch_discard;
   endsequence
   skip_two_a: assert property (taken && skip_c |=> dummy_s)
      else $error("taken skip not two cycles");
   no_skip_a: assert property (taken && !skip_c |=> done && !busy && !fetch_discard)
      else $error("untaken skip not one cycle");
   flags_hold_a: assert property (taken && op_code inside {MRS_OP_ROR_M, MRS_OP_ROR_W, MRS_OP_SETB,
      MRS_OP_SETBIT, MRS_OP_DSZ, MRS_OP_DSZW, MRS_OP_ISZ, MRS_OP_ISZW, MRS_OP_SBS, MRS_OP_NSW, MRS_OP_NSWW}
      |=> $stable(flg))
      else $error("flags changed");
   rot_right_a: assert property (taken && op_code == MRS_OP_ROR_M
      |=> mem_we && mem_wdata == {m_q[0], m_q[7:1]})
      else $error("rotate right wrong");
   rorc_mem_a: assert property (taken && op_code == MRS_OP_RORC_M
      |=> mem_wdata == {c_q, m_q[7:1]} && carry == m_q[0])
      else $error("rotate through carry wrong");
   rolc_work_a: assert property (taken && op_code == MRS_OP_ROLC_W
      |=> working_register == {m_q[6:0], c_q} && !mem_we)
      else $error("left rotate to working wrong");
   set_byte_a: assert property (taken && op_code == MRS_OP_SETB |=> mem_we && mem_wdata == 8'hFF)
      else $error("set byte wrong");
   swap_mem_a: assert property (taken && op_code == MRS_OP_NSW
      |=> mem_we && mem_wdata == {m_q[3:0], m_q[7:4]})
      else $error("nibble swap wrong");
   sub_imm_a: assert property (taken && op_code == MRS_OP_SUBI |=> working_register == 8'(w_q - x_q))
      else $error("immediate subtract wrong");
   dec_mem_a: assert property (taken && op_code == MRS_OP_DSZ |=> mem_we && mem_wdata == 8'(m_q - 8'h01))
      else $error("decrement write wrong");
endmodule
bind mrs_datapath mrs_datapath_checker #(.DATA_W(DATA_W)) chk (.mclk(mclk), .reset_n(reset_n), .op_valid(op_valid),
   .op_code(op_code), .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel),
   .working_register(working_register), .carry(carry), .half_carry_flag(half_carry_flag), .zero(zero),
   .signed_range_error_flag(signed_range_error_flag), .mem_wdata(mem_wdata), .mem_we(mem_we), .busy(busy),
   .fetch_discard(fetch_discard), .done(done));

// ### verification/mrs_datapath_tb.sv
`timescale 1ns/1ps
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH %0t %0h %0h", $time, a, b); end end
module mrs_datapath_tb;
   import mrs_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic op_valid = 1'b0;
   mrs_op_t op_code = MRS_OP_NONE;
   logic [7:0] mem_rdata = 8'h00;
   logic [7:0] imm_data = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [7:0] working_register, mem_wdata, r_wd;
   logic carry, half_carry_flag, zero, signed_range_error_flag, mem_we, busy, fetch_discard, done, r_we, r_sk;
   int r_cy;
   int err_count = 0;
   int n_checks = 0;
   mrs_datapath DUT (.mclk(mclk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
      .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel), .working_register(working_register),
      .carry(carry), .half_carry_flag(half_carry_flag), .zero(zero),
      .signed_range_error_flag(signed_range_error_flag), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .busy(busy), .fetch_discard(fetch_discard), .done(done));
   // Free running clock
   always #12.5 mclk = ~mclk;
   task give_verdict;
      if (err_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One operation, entered 1 ns after an edge; ops follow back to back
   task automatic do_op(input mrs_op_t o, input logic [7:0] m, input logic [7:0] x, input logic [2:0] b);
      op_code = o;
      mem_rdata = m;
      imm_data = x;
      bit_sel = b;
      op_valid = 1'b1;
      @(posedge mclk);
      #1;
      op_valid = 1'b0;
      mem_rdata = ~m; // Stale memory data must not be reused
      r_we = mem_we;
      r_wd = mem_wdata;
      r_sk = fetch_discard;
      r_cy = 1;
      for (int i = 0; i < 4 && done !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
         r_cy++;
      end
      if (done !== 1'b1)
      begin
         err_count++;
         give_verdict();
      end
   endtask
   // Rotations, starting from working 00 and carry 0
   task t_rotate;
      do_op(MRS_OP_ROLC_W, 8'hA5, 8'h00, 3'h0);
      `CHK({working_register, carry, r_we}, {8'h4A, 1'b1, 1'b0})
      do_op(MRS_OP_RORC_W, 8'h3C, 8'h00, 3'h0);
      `CHK({working_register, carry, r_we}, {8'h9E, 1'b0, 1'b0})
      do_op(MRS_OP_RORC_M, 8'h81, 8'h00, 3'h0);
      `CHK({r_wd, carry, r_we}, {8'h40, 1'b1, 1'b1})
      do_op(MRS_OP_ROR_M, 8'h01, 8'h00, 3'h0);
      `CHK({r_wd, carry, r_we}, {8'h80, 1'b1, 1'b1})
      do_op(MRS_OP_ROR_W, 8'h03, 8'h00, 3'h0);
      `CHK({working_register, carry, r_we}, {8'h81, 1'b1, 1'b0})
   endtask
   // Subtracts; flag order is carry, half carry, zero, overflow
   task t_sub;
      do_op(MRS_OP_SUBI, 8'h00, 8'h01, 3'h0);
      `CHK({working_register, carry, half_carry_flag, zero, signed_range_error_flag}, {8'h80, 4'hC})
      do_op(MRS_OP_SUB, 8'h01, 8'h00, 3'h0);
      `CHK({working_register, carry, half_carry_flag, zero, signed_range_error_flag}, {8'h7F, 4'h9})
      do_op(MRS_OP_SUBC_W, 8'h7F, 8'h00, 3'h0);
      `CHK({working_register, carry, half_carry_flag, zero, signed_range_error_flag}, {8'h00, 4'hE})
      do_op(MRS_OP_SUBC_M, 8'h01, 8'h00, 3'h0);
      `CHK({r_wd, r_we, working_register, carry, half_carry_flag, zero}, {8'hFF, 1'b1, 8'h00, 3'h0})
      do_op(MRS_OP_SUB_M, 8'h00, 8'h00, 3'h0);
      `CHK({r_wd, r_we, carry, half_carry_flag, zero, signed_range_error_flag}, {8'h00, 1'b1, 4'hE})
   endtask
   // One skip case: cycle count, discard pulse, carry kept, result where it belongs
   task automatic sk(input mrs_op_t o, input logic [7:0] m, input logic [2:0] b, input logic s, input logic [7:0] v);
      logic c0;
      c0 = carry;
      do_op(o, m, 8'h00, b);
      `CHK({r_cy, r_sk, carry}, {(s ? 2 : 1), s, c0})
      if (o inside {MRS_OP_DSZ, MRS_OP_ISZ})
         `CHK({r_we, r_wd}, {1'b1, v})
      else if (o inside {MRS_OP_DSZW, MRS_OP_ISZW})
         `CHK({r_we, working_register}, {1'b0, v})
   endtask
   task t_skip;
      sk(MRS_OP_DSZ, 8'h01, 3'h0, 1'b1, 8'h00);
      sk(MRS_OP_DSZ, 8'h02, 3'h0, 1'b0, 8'h01);
      sk(MRS_OP_DSZW, 8'h01, 3'h0, 1'b1, 8'h00);
      sk(MRS_OP_ISZ, 8'hFF, 3'h0, 1'b1, 8'h00);
      sk(MRS_OP_ISZW, 8'hFE, 3'h0, 1'b0, 8'hFF);
      sk(MRS_OP_SBS, 8'h08, 3'h3, 1'b1, 8'h00);
      sk(MRS_OP_SBS, 8'hF7, 3'h3, 1'b0, 8'h00);
      sk(MRS_OP_SZB, 8'h00, 3'h0, 1'b1, 8'h00);
      sk(MRS_OP_SZB, 8'h01, 3'h0, 1'b0, 8'h00);
   endtask
   // Byte set, bit set and nibble swaps
   task t_bits;
      do_op(MRS_OP_SETB, 8'h12, 8'h00, 3'h0);
      `CHK({r_we, r_wd}, {1'b1, 8'hFF})
      do_op(MRS_OP_SETBIT, 8'h10, 8'h00, 3'h7);
      `CHK({r_we, r_wd}, {1'b1, 8'h90})
      do_op(MRS_OP_NSW, 8'h3C, 8'h00, 3'h0);
      `CHK({r_we, r_wd}, {1'b1, 8'hC3})
      do_op(MRS_OP_NSWW, 8'hA7, 8'h00, 3'h0);
      `CHK({r_we, working_register, carry}, {1'b0, 8'h7A, 1'b1})
   endtask
   // Reset, then scenarios in order; flag state carries from one to the next
   initial
   begin
      repeat (4) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      `CHK({working_register, carry, mem_we, busy, done}, {8'h00, 4'h0})
      t_rotate();
      t_sub();
      t_skip();
      t_bits();
      give_verdict();
   end
endmodule
